// ==== cdiu_top.sv ====
`timescale 1ns/1ps
`include "cdiu_defines.svh"
// Operation
// - A/B timing violation raises illegal-ratio error 0x500.
// - Broken A, B or N line raises wire-break error 0x505.
// - Excess temperature raises overheating error 0x506.
// - Error indicator flashes while any diagnostic error is pending.
// - Error indicator goes dark once no fault remains.
// - Two enables: wire-break interrupt and additional-errors interrupt.
// - Both enables are cleared by reset.
// - Internal and watchdog errors always interrupt, no enable needed.
// - Wire-break monitoring only with push-pull encoder configured.
// - Wire-break interrupts only when its enable is set.
// - Other faults always monitored; interrupt only with additional enable.
// - Normal functions continue unaffected while errors are pending.
// - Each interrupt carries the code of its triggering cause.
// - Detailed error data stays readable via extra-info read request.
// - Hardware interrupt lost raises error 0x16.
// - Internal defect reports 0x100, watchdog expiry 0x103.
// - Supply missing 0x10A, encoder supply fault 0x10E, faulty supply 0x110.
// - Digital output fault raises error 0x10F.
module cdiu_top (
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Configuration
  input wire logic cfg_load,
  input wire logic cfg_wire_break_en,
  input wire logic cfg_extra_en,
  input wire logic cfg_push_pull,
  // Fault conditions
  input wire logic flt_ab_ratio,
  input wire logic flt_wire_break,
  input wire logic flt_overheat,
  input wire logic flt_internal,
  input wire logic flt_watchdog,
  input wire logic flt_hw_int_lost,
  input wire logic flt_supply_missing,
  input wire logic flt_enc_supply,
  input wire logic flt_output,
  input wire logic flt_supply_faulty,
  // Controller side
  input wire logic irq_ack,
  input wire logic read_extra_alarm_info,
  output cdiu_pkg::cdiu_report_type irq_out,
  output cdiu_pkg::cdiu_report_type info_out,
  output logic info_valid,
  // Indicator and status
  output logic error_led,
  output logic [9:0] pending_out
);

  // ----------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------
  logic wb_en_ff, nxt_wb_en;
  logic ex_en_ff, nxt_ex_en;

  always_comb begin
    nxt_wb_en = wb_en_ff;
    nxt_ex_en = ex_en_ff;
    if (cfg_load) begin
      nxt_wb_en = cfg_wire_break_en;
      nxt_ex_en = cfg_extra_en;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_en_ff <= `CDIU_EN_RESET;
      ex_en_ff <= `CDIU_EN_RESET;
    end else if (clk_en) begin
      wb_en_ff <= nxt_wb_en;
      ex_en_ff <= nxt_ex_en;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  // Pending follows the live condition, so it drops the cycle after clearing.
  cdiu_pkg::cdiu_cause_type cond;
  cdiu_pkg::cdiu_cause_type gate;
  cdiu_pkg::cdiu_cause_type pend_ff, nxt_pend;
  cdiu_pkg::cdiu_cause_type seen_ff, nxt_seen;

  always_comb begin
    cond = '0;
    cond[`CDIU_CAUSE_HW_INT_LOST] = flt_hw_int_lost;
    cond[`CDIU_CAUSE_INTERNAL] = flt_internal;
    cond[`CDIU_CAUSE_WATCHDOG] = flt_watchdog;
    cond[`CDIU_CAUSE_SUPPLY_MISSING] = flt_supply_missing;
    cond[`CDIU_CAUSE_ENC_SUPPLY] = flt_enc_supply;
    cond[`CDIU_CAUSE_OUTPUT_ERR] = flt_output;
    cond[`CDIU_CAUSE_SUPPLY_FAULTY] = flt_supply_faulty;
    cond[`CDIU_CAUSE_AB_RATIO] = flt_ab_ratio;
    cond[`CDIU_CAUSE_WIRE_BREAK] = flt_wire_break & cfg_push_pull;
    cond[`CDIU_CAUSE_OVERHEAT] = flt_overheat;
    gate = {10{ex_en_ff}};
    gate[`CDIU_CAUSE_INTERNAL] = 1'b1;
    gate[`CDIU_CAUSE_WATCHDOG] = 1'b1;
    gate[`CDIU_CAUSE_WIRE_BREAK] = wb_en_ff;
    nxt_pend = cond;
  end

  // ----------------------------------------------------------------
  // Code lookup
  // ----------------------------------------------------------------
  function automatic cdiu_pkg::cdiu_code_type cdiu_code_of(input int idx);
    cdiu_pkg::cdiu_code_type c;
    c = `CDIU_CODE_INTERNAL;
    unique case (idx)
      `CDIU_CAUSE_HW_INT_LOST: c = `CDIU_CODE_HW_INT_LOST;
      `CDIU_CAUSE_INTERNAL: c = `CDIU_CODE_INTERNAL;
      `CDIU_CAUSE_WATCHDOG: c = `CDIU_CODE_WATCHDOG;
      `CDIU_CAUSE_SUPPLY_MISSING: c = `CDIU_CODE_SUPPLY_MISSING;
      `CDIU_CAUSE_ENC_SUPPLY: c = `CDIU_CODE_ENC_SUPPLY;
      `CDIU_CAUSE_OUTPUT_ERR: c = `CDIU_CODE_OUTPUT_ERR;
      `CDIU_CAUSE_SUPPLY_FAULTY: c = `CDIU_CODE_SUPPLY_FAULTY;
      `CDIU_CAUSE_AB_RATIO: c = `CDIU_CODE_AB_RATIO;
      `CDIU_CAUSE_WIRE_BREAK: c = `CDIU_CODE_WIRE_BREAK;
      default: c = `CDIU_CODE_OVERHEAT;
    endcase
    return c;
  endfunction : cdiu_code_of

  // ----------------------------------------------------------------
  // Interrupt sequencer
  // ----------------------------------------------------------------
  // One interrupt is outstanding at a time; each new gated cause is raised once
  // per occurrence, lowest index first.
  cdiu_pkg::cdiu_state_type st_ff, nxt_st;
  cdiu_pkg::cdiu_report_type irq_ff, nxt_irq;
  cdiu_pkg::cdiu_report_type info_ff, nxt_info;
  logic info_valid_ff, nxt_info_valid;
  cdiu_pkg::cdiu_cause_type fresh;
  int pick;

  always_comb begin
    fresh = cond & gate & ~seen_ff;
    pick = 0;
    for (int i = `CDIU_NUM_CAUSES - 1; i >= 0; i--) begin
      if (fresh[i]) begin
        pick = i;
      end
    end
    nxt_st = st_ff;
    nxt_irq = irq_ff;
    nxt_info = info_ff;
    nxt_info_valid = 1'b0;
    nxt_seen = seen_ff & cond;
    unique case (st_ff)
      cdiu_pkg::CDIU_IDLE: begin
        if (|fresh) begin
          nxt_irq.valid = 1'b1;
          nxt_irq.code = cdiu_code_of(pick);
          nxt_irq.pending = cond;
          nxt_info = nxt_irq;
          nxt_seen[pick] = 1'b1;
          nxt_st = cdiu_pkg::CDIU_WAIT;
        end
      end
      cdiu_pkg::CDIU_WAIT: begin
        if (irq_ack) begin
          nxt_irq.valid = 1'b0;
          nxt_st = cdiu_pkg::CDIU_IDLE;
        end
      end
      // A corrupted state code withdraws any request and returns to idle.
      default: begin
        nxt_irq.valid = 1'b0;
        nxt_st = cdiu_pkg::CDIU_IDLE;
      end
    endcase
    if (read_extra_alarm_info) begin
      nxt_info_valid = 1'b1;
      nxt_info.pending = cond;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= cdiu_pkg::CDIU_IDLE;
      irq_ff <= '0;
      info_ff <= '0;
      info_valid_ff <= 1'b0;
      pend_ff <= '0;
      seen_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      irq_ff <= nxt_irq;
      info_ff <= nxt_info;
      info_valid_ff <= nxt_info_valid;
      pend_ff <= nxt_pend;
      seen_ff <= nxt_seen;
    end
  end

  // ----------------------------------------------------------------
  // Error indicator
  // ----------------------------------------------------------------
  logic [23:0] flash_cnt_ff, nxt_flash_cnt;
  logic led_ff, nxt_led;

  always_comb begin
    nxt_flash_cnt = flash_cnt_ff;
    nxt_led = led_ff;
    if (|cond) begin
      if (flash_cnt_ff == 24'(`CDIU_FLASH_HALF_CYC - 1)) begin
        nxt_flash_cnt = '0;
        nxt_led = ~led_ff;
      end else begin
        nxt_flash_cnt = flash_cnt_ff + 24'h000001;
      end
    end else begin
      // Preloading the terminal count lights the indicator on the first faulty cycle,
      // instead of leaving it dark for half a flash period.
      nxt_flash_cnt = 24'(`CDIU_FLASH_HALF_CYC - 1);
      nxt_led = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_cnt_ff <= 24'(`CDIU_FLASH_HALF_CYC - 1);
      led_ff <= 1'b0;
    end else if (clk_en) begin
      flash_cnt_ff <= nxt_flash_cnt;
      led_ff <= nxt_led;
    end
  end

  // Faults never block other outputs; the unit only reports.
  assign irq_out = irq_ff;
  assign info_out = info_ff;
  assign info_valid = info_valid_ff;
  assign error_led = led_ff;
  assign pending_out = pend_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_rst_enables: assert property (@(posedge ref_clk) rst |=> !wb_en_ff && !ex_en_ff)
    else $error("enables not cleared by reset");
  chk_led_off: assert property (@(posedge ref_clk) disable iff (rst) clk_en && !(|cond) |=> !error_led)
    else $error("led lit without fault");
  chk_wd_irq: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && st_ff == cdiu_pkg::CDIU_IDLE && flt_watchdog && !seen_ff[2] && !(|fresh[1:0])
    |=> irq_out.valid && irq_out.code == 16'h0103)
    else $error("watchdog not reported");
  chk_wb_gate: assert property (@(posedge ref_clk) disable iff (rst)
    irq_out.valid && irq_out.code == 16'h0505 && $rose(irq_out.valid) |-> $past(wb_en_ff) && $past(cfg_push_pull))
    else $error("wire break interrupt without enable");
  chk_extra_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq_out.valid) && irq_out.code == 16'h0500 |-> $past(ex_en_ff))
    else $error("additional error interrupt without enable");
  chk_pend_follow: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !flt_overheat |=> !pending_out[9])
    else $error("pending not dropped");
  chk_info_resp: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && read_extra_alarm_info |=> info_valid)
    else $error("info read not answered");
  chk_irq_hold: assert property (@(posedge ref_clk) disable iff (rst)
    irq_out.valid && !irq_ack |=> irq_out.valid && $stable(irq_out.code))
    else $error("interrupt dropped before ack");
  chk_led_lit: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && (|cond) && !(|pend_ff) |=> error_led)
    else $error("indicator not lit on new fault");
  chk_int_irq: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && st_ff == cdiu_pkg::CDIU_IDLE && flt_internal && !seen_ff[1] && !fresh[0]
    |=> irq_out.valid && irq_out.code == `CDIU_CODE_INTERNAL)
    else $error("internal error not reported");
  chk_wb_mask: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !cfg_push_pull |=> !pending_out[8])
    else $error("wire break monitored without push-pull");
  chk_pend_live: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> pending_out == $past(cond))
    else $error("pending does not follow conditions");
  chk_info_snap: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && st_ff == cdiu_pkg::CDIU_IDLE && (|fresh) |=> info_out.code == irq_out.code)
    else $error("detail data does not match interrupt");
  chk_ack_drop: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && irq_out.valid && irq_ack |=> !irq_out.valid)
    else $error("interrupt not withdrawn after ack");
  chk_rst_quiet: assert property (@(posedge ref_clk) rst |=> !irq_out.valid && !info_valid && !error_led)
    else $error("outputs not quiet after reset");

  // ----------------------------------------------------------------
  // Checks on causes and codes
  // ----------------------------------------------------------------
  chk_ab_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq_out.valid) && irq_out.code == `CDIU_CODE_AB_RATIO |-> $past(flt_ab_ratio))
    else $error("ratio interrupt without ratio fault");
  chk_heat_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq_out.valid) && irq_out.code == `CDIU_CODE_OVERHEAT |-> $past(flt_overheat))
    else $error("overheat interrupt without overheat fault");
  chk_lost_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq_out.valid) && irq_out.code == `CDIU_CODE_HW_INT_LOST |-> $past(flt_hw_int_lost) && $past(ex_en_ff))
    else $error("lost-interrupt report without cause or enable");
  chk_wb_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(irq_out.valid) && irq_out.code == `CDIU_CODE_WIRE_BREAK |-> $past(flt_wire_break))
    else $error("wire break interrupt without wire break fault");
endmodule : cdiu_top

// ==== cdiu_defines.svh ====
`ifndef CDIU_DEFINES_SVH
`define CDIU_DEFINES_SVH
// ----------------------------------------------------------------
// Error codes
// ----------------------------------------------------------------
`define CDIU_CODE_HW_INT_LOST 16'h0016
`define CDIU_CODE_INTERNAL 16'h0100
`define CDIU_CODE_WATCHDOG 16'h0103
`define CDIU_CODE_SUPPLY_MISSING 16'h010A
`define CDIU_CODE_ENC_SUPPLY 16'h010E
`define CDIU_CODE_OUTPUT_ERR 16'h010F
`define CDIU_CODE_SUPPLY_FAULTY 16'h0110
`define CDIU_CODE_AB_RATIO 16'h0500
`define CDIU_CODE_WIRE_BREAK 16'h0505
`define CDIU_CODE_OVERHEAT 16'h0506
// ----------------------------------------------------------------
// Cause bit positions
// ----------------------------------------------------------------
`define CDIU_CAUSE_HW_INT_LOST 0
`define CDIU_CAUSE_INTERNAL 1
`define CDIU_CAUSE_WATCHDOG 2
`define CDIU_CAUSE_SUPPLY_MISSING 3
`define CDIU_CAUSE_ENC_SUPPLY 4
`define CDIU_CAUSE_OUTPUT_ERR 5
`define CDIU_CAUSE_SUPPLY_FAULTY 6
`define CDIU_CAUSE_AB_RATIO 7
`define CDIU_CAUSE_WIRE_BREAK 8
`define CDIU_CAUSE_OVERHEAT 9
`define CDIU_NUM_CAUSES 10
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CDIU_EN_RESET 1'b0
`define CDIU_CLK_HZ 10000000
`define CDIU_FLASH_HZ 2
`define CDIU_FLASH_HALF_CYC (`CDIU_CLK_HZ / (2 * `CDIU_FLASH_HZ))
`endif

// ==== cdiu_pkg.sv ====
package cdiu_pkg;
  typedef logic [15:0] cdiu_code_type;
  typedef logic [9:0] cdiu_cause_type;
  typedef struct packed {
    logic valid;
    cdiu_code_type code;
    cdiu_cause_type pending;
  } cdiu_report_type;
  typedef enum logic [1:0] {
    CDIU_IDLE = 2'b01,
    CDIU_WAIT = 2'b10
  } cdiu_state_type;
endpackage : cdiu_pkg

// ==== cdiu_ctrl_model.sv ====
`timescale 1ns/1ps
module cdiu_ctrl_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Interrupt link
  input cdiu_pkg::cdiu_report_type irq_out,
  input wire logic slow,
  output logic irq_ack,
  output int irq_cnt,
  output cdiu_pkg::cdiu_code_type last_code
);
  // ------------
  // Acknowledge
  // ------------
  // A slow controller lets the request stand for a few cycles, as a busy CPU would.
  int dly;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ack <= 1'b0;
      dly <= 0;
      irq_cnt <= 0;
      last_code <= 16'h0000;
    end else if (irq_out.valid && !irq_ack) begin
      if (dly >= (slow ? 3 : 0)) begin
        irq_ack <= 1'b1;
        dly <= 0;
        irq_cnt <= irq_cnt + 1;
        last_code <= irq_out.code;
      end else begin
        dly <= dly + 1;
      end
    end else begin
      irq_ack <= 1'b0;
    end
  end
endmodule : cdiu_ctrl_model

// ==== test_counter_diag_interrupt_unit.sv ====
`timescale 1ns/1ps
module test_counter_diag_interrupt_unit;
  // ------------
  // Signals
  // ------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_load = 1'b0;
  logic wb_en = 1'b0;
  logic ex_en = 1'b0;
  logic pp = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic [9:0] flt = 10'h000;
  logic irq_ack;
  logic info_valid;
  logic error_led;
  logic [9:0] pending_out;
  cdiu_pkg::cdiu_report_type irq_out;
  cdiu_pkg::cdiu_report_type info_out;
  cdiu_pkg::cdiu_code_type last_code;
  int irq_cnt;
  int n0;
  int num_errors = 0;
  int tests_run = 0;
  cdiu_pkg::cdiu_code_type codes [10] = '{16'h0016, 16'h0100, 16'h0103, 16'h010A, 16'h010E,
    16'h010F, 16'h0110, 16'h0500, 16'h0505, 16'h0506};
  always #50 ref_clk = ~ref_clk;
  cdiu_top i_cdiu_top (.ref_clk(ref_clk), .rst(rst), .clk_en(ce), .cfg_load(cfg_load),
    .cfg_wire_break_en(wb_en), .cfg_extra_en(ex_en), .cfg_push_pull(pp),
    .flt_ab_ratio(flt[7]), .flt_wire_break(flt[8]), .flt_overheat(flt[9]),
    .flt_internal(flt[1]), .flt_watchdog(flt[2]), .flt_hw_int_lost(flt[0]),
    .flt_supply_missing(flt[3]), .flt_enc_supply(flt[4]), .flt_output(flt[5]),
    .flt_supply_faulty(flt[6]), .irq_ack(irq_ack), .read_extra_alarm_info(rd),
    .irq_out(irq_out), .info_out(info_out), .info_valid(info_valid),
    .error_led(error_led), .pending_out(pending_out));
  cdiu_ctrl_model i_cdiu_ctrl_model (.ref_clk(ref_clk), .rst(rst), .irq_out(irq_out),
    .slow(slow), .irq_ack(irq_ack), .irq_cnt(irq_cnt), .last_code(last_code));
  // ------------
  // Helpers
  // ------------
  function automatic logic irq_due(int i);
    if (i == 1 || i == 2) return 1'b1;
    if (i == 8) return wb_en & pp;
    return ex_en;
  endfunction : irq_due
  task automatic chk(string what, logic [26:0] exp, logic [26:0] got);
    tests_run++;
    if (exp !== got) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic configure(logic wb, logic ex, logic p);
    @(posedge ref_clk);
    wb_en <= wb;
    ex_en <= ex;
    pp <= p;
    cfg_load <= 1'b1;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
  endtask : configure
  // Raises one fault alone, waits for the controller, reads the detail data if an interrupt is due, then clears it.
  task automatic one_fault(int i);
    @(negedge ref_clk);
    n0 = irq_cnt;
    @(posedge ref_clk);
    flt <= 10'h001 << i;
    slow <= 1'($urandom);
    repeat (12) @(negedge ref_clk);
    chk("pending", (i == 8 && !pp) ? 27'h0 : 27'h1 << i, 27'(pending_out));
    chk("led on", (i == 8 && !pp) ? 27'h0 : 27'h1, 27'(error_led));
    chk("irq count", 27'(irq_due(i)), 27'(irq_cnt - n0));
    if (irq_due(i)) begin
      chk("irq code", 27'(codes[i]), 27'(last_code));
      chk("irq pending", 27'h1 << i, 27'(irq_out.pending));
      chk("irq withdrawn", 27'h0, 27'(irq_out.valid));
      @(posedge ref_clk);
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      chk("info valid", 27'h1, 27'(info_valid));
      chk("info code", 27'(codes[i]), 27'(info_out.code));
      chk("info pending", 27'h1 << i, 27'(info_out.pending));
    end
    @(posedge ref_clk);
    flt <= 10'h000;
    repeat (3) @(negedge ref_clk);
    chk("pending clear", 27'h0, 27'(pending_out));
    chk("led off", 27'h0, 27'(error_led));
  endtask : one_fault
  // ------------
  // Sequence
  // ------------
  initial begin
    void'($urandom(61665));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    pp <= 1'b1;
    one_fault(7);
    one_fault(8);
    for (int c = 0; c < 8; c++) begin
      configure(c[0], c[1], c[2]);
      for (int i = 0; i < 10; i++) begin
        one_fault(i);
      end
    end
    configure(1'b1, 1'b1, 1'b1);
    // Two faults at once: the lower cause goes first, so the last code seen is the higher one.
    @(negedge ref_clk);
    n0 = irq_cnt;
    @(posedge ref_clk);
    flt <= 10'h204;
    repeat (16) @(negedge ref_clk);
    chk("pair count", 27'h2, 27'(irq_cnt - n0));
    chk("pair last code", 27'(codes[9]), 27'(last_code));
    @(posedge ref_clk);
    flt <= 10'h000;
    for (int k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      flt <= 10'($urandom);
      repeat (2) @(negedge ref_clk);
      chk("pending random", 27'(flt), 27'(pending_out));
    end
    @(posedge ref_clk);
    ce <= 1'b0;
    flt <= ~flt;
    repeat (3) @(negedge ref_clk);
    chk("pending frozen", {17'h00000, ~flt}, 27'(pending_out));
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("pending resumed", 27'(flt), 27'(pending_out));
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end
endmodule : test_counter_diag_interrupt_unit
